/* hdl/counter_system_settings.sv */
// Settings command decoder with AXI4-Lite register access
`timescale 1ns/1ps

module counter_system_settings
   import counter_settings_pkg::*;
(
   input  wire logic                                    aclk,
   input  wire logic                                    aresetn,
   input  wire logic [counter_settings_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                                    awvalid,
   output wire logic                                    awready,
   input  wire logic [31:0]                             wdata,
   input  wire logic [3:0]                              wstrb,
   input  wire logic                                    wvalid,
   output wire logic                                    wready,
   output wire logic [1:0]                              bresp,
   output wire logic                                    bvalid,
   input  wire logic                                    bready,
   input  wire logic [counter_settings_pkg::ADDR_W-1:0] araddr,
   input  wire logic                                    arvalid,
   output wire logic                                    arready,
   output wire logic [31:0]                             rdata,
   output wire logic [1:0]                              rresp,
   output wire logic                                    rvalid,
   input  wire logic                                    rready,
   input  wire logic                                    bus_reset,
   input  wire logic                                    source_in,
   input  wire logic                                    gate_in,
   output wire counter_settings_pkg::cond_out_s         cond,
   output wire counter_settings_pkg::mode_e             mode,
   output wire logic                                    count_run,
   output wire logic                                    out_clear,
   output wire logic [9:0]                              pulse_len_ms,
   output wire logic [14:0]                             pulse_freq_hz
);
   import counter_settings_pkg::*;

   typedef struct packed {
      logic              up;
      wr_e               wr;
      logic              awready;
      logic              wready;
      logic              aw_have;
      logic              w_have;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [15:0]       cmd_word;
      logic [15:0]       word1;
      mode_e             mode;
      logic [4:0]        factor;
      logic [1:0]        sel;
      logic [3:0]        lut;
      logic              bus_ignore;
      logic [2:0]        pend_len;
      logic [2:0]        act_len;
      logic              run;
      logic              out_clear;
      logic [9:0]        len_ms;
      logic [14:0]       freq_hz;
      cond_out_s         cond;
   } st_s;

   st_s s;
   st_s n;

   logic              do_wr;
   logic [ADDR_W-1:0] wr_addr;
   logic [15:0]       wr_data;
   logic [1:0]        cmd_sel;
   logic [5:0]        cmd_code;
   logic              counting;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a == ADDR_CMD) || (a == ADDR_WORD1) ||
             (a == ADDR_MODE) || (a == ADDR_STATUS);
   endfunction

   always_comb begin
      n = s;
      n.out_clear = 1'b0;
      do_wr = 1'b0;
      wr_addr = s.awaddr;
      wr_data = 16'h0000;
      cmd_sel = 2'h0;
      cmd_code = 6'h00;
      counting = 1'b0;

      // Readies rise one edge after reset release
      if (!s.up) begin
         n.up = 1'b1;
         n.awready = 1'b1;
         n.wready = 1'b1;
         n.arready = 1'b1;
      end

      // Address and data may arrive in either order
      if (s.awready && awvalid) begin
         n.awready = 1'b0;
         n.aw_have = 1'b1;
         n.awaddr = awaddr;
      end
      if (s.wready && wvalid) begin
         n.wready = 1'b0;
         n.w_have = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end

      if (n.aw_have && n.w_have && s.wr == WR_IDLE) begin
         do_wr = 1'b1;
         wr_addr = n.awaddr;
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.wr = WR_RESP;
         n.bresp = mapped(n.awaddr) ? RESP_OKAY : RESP_SLVERR;
         case (n.awaddr)
            ADDR_CMD: begin
               wr_data = merge16(s.cmd_word, n.wdata, n.wstrb);
               n.cmd_word = wr_data;
               cmd_code = wr_data[CODE_MSB:CODE_LSB];
               cmd_sel = wr_data[SEL_MSB:SEL_LSB];
               case (cmd_code)
                  CODE_SETTINGS: begin
                     // Pulse generator owns the input stage
                     if (s.mode == MODE_PULSEGEN) begin
                        n.sel = SEL_PULSEGEN;
                     end else begin
                        n.sel = cmd_sel;
                     end
                     if (n.sel == SEL_LOGIC) begin
                        n.lut = wr_data[LUT_MSB:LUT_LSB];
                     end
                     n.bus_ignore = wr_data[BRST_BIT];
                     n.pend_len = wr_data[LEN_MSB:0];
                  end
                  CODE_DEFAULT: begin
                     n.pend_len = LEN_DEFAULT;
                     n.act_len = LEN_DEFAULT;
                     n.sel = SEL_DIRECT;
                     n.run = 1'b0;
                     n.mode = MODE_NONE;
                     n.freq_hz = 15'h0000;
                  end
                  CODE_STOP: begin
                     n.run = 1'b0;
                  end
                  CODE_START: begin
                     n.run = (s.mode == MODE_EVENT);
                  end
                  default: begin
                     n.cmd_word = wr_data;
                  end
               endcase
            end
            // Kept for readback only, never decoded
            ADDR_WORD1: begin
               n.word1 = merge16(s.word1, n.wdata, n.wstrb);
            end
            ADDR_MODE: begin
               wr_data = merge16({3'h0, s.factor, 5'h00, s.mode}, n.wdata, n.wstrb);
               n.factor = wr_data[FACT_MSB:FACT_LSB];
               case (wr_data[MODE_MSB:0])
                  MODE_FREQ: begin
                     n.mode = MODE_FREQ;
                     n.run = 1'b1;
                  end
                  MODE_EVENT: begin
                     n.mode = MODE_EVENT;
                     n.run = 1'b1;
                     n.act_len = s.pend_len;
                  end
                  MODE_TIME: begin
                     n.mode = MODE_TIME;
                     n.run = 1'b1;
                  end
                  MODE_PULSEGEN: begin
                     n.mode = MODE_PULSEGEN;
                     n.run = 1'b0;
                     n.sel = SEL_PULSEGEN;
                  end
                  default: begin
                     n.mode = MODE_NONE;
                     n.run = 1'b0;
                  end
               endcase
            end
            default: begin
               n.bresp = n.bresp;
            end
         endcase
      end

      if (s.bvalid && bready) begin
         n.bvalid = 1'b0;
         n.wr = WR_IDLE;
         n.awready = 1'b1;
         n.wready = 1'b1;
      end

      // A same-cycle write updates the ignore bit first; an unignored bus reset then wins over its mode and run
      if (bus_reset && !n.bus_ignore) begin
         n.mode = MODE_NONE;
         n.run = 1'b0;
         n.out_clear = 1'b1;
      end

      if (n.mode == MODE_PULSEGEN) begin
         n.freq_hz = FREQ_BASE_HZ + 15'(n.factor) * FREQ_STEP_HZ;
      end else begin
         n.freq_hz = 15'h0000;
      end
      n.len_ms = PULSE_MS[n.act_len];

      if (s.arready && arvalid) begin
         n.arready = 1'b0;
         n.rvalid = 1'b1;
         n.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            ADDR_CMD:    n.rdata = {16'h0000, s.cmd_word};
            ADDR_WORD1:  n.rdata = {16'h0000, s.word1};
            ADDR_MODE:   n.rdata = {19'h0, s.factor, 5'h00, s.mode};
            ADDR_STATUS: n.rdata = {15'h0, s.run, 1'b0, s.act_len, 2'h0,
                                    s.sel, s.lut, s.bus_ignore, s.pend_len};
            default:     n.rdata = 32'h0000_0000;
         endcase
      end
      if (s.rvalid && rready) begin
         n.rvalid = 1'b0;
         n.arready = 1'b1;
      end

      // Conditioning stage; engines downstream do the filtering.
      // Bounce filters hurt solid-state inputs, so software decides.
      n.cond.gate = gate_in;
      counting = (n.mode == MODE_FREQ) || (n.mode == MODE_EVENT) || (n.mode == MODE_TIME);
      n.cond.logic_active = counting && (n.sel == SEL_LOGIC);
      n.cond.src = n.cond.logic_active ?
                   n.lut[{gate_in, source_in}] : source_in;
      n.cond.filt_100k = (n.sel == SEL_DIRECT);
      n.cond.filt_bounce = counting && (n.sel == SEL_BOUNCE);
      n.cond.pulsegen_setup = (n.sel == SEL_PULSEGEN);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.pend_len <= LEN_DEFAULT;
         s.act_len <= LEN_DEFAULT;
         s.len_ms <= PULSE_MS[LEN_DEFAULT];
      end else begin
         s <= n;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bresp = s.bresp;
   assign bvalid = s.bvalid;
   assign arready = s.arready;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign rvalid = s.rvalid;
   assign cond = s.cond;
   assign mode = s.mode;
   assign count_run = s.run;
   assign out_clear = s.out_clear;
   assign pulse_len_ms = s.len_ms;
   assign pulse_freq_hz = s.freq_hz;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_settings_wr;
      do_wr && wr_addr == ADDR_CMD && cmd_code == CODE_SETTINGS;
   endsequence

   sequence s_default_wr;
      do_wr && wr_addr == ADDR_CMD && cmd_code == CODE_DEFAULT;
   endsequence

   property p_sel_take;
      s_settings_wr ##0 (s.mode != MODE_PULSEGEN) |=> s.sel == $past(cmd_sel);
   endproperty
   a_sel_take: assert property (p_sel_take) else $error("selection not taken");

   property p_pg_force;
      s.mode == MODE_PULSEGEN |-> s.sel == SEL_PULSEGEN && s.cond.logic_active == 1'b0;
   endproperty
   a_pg_force: assert property (p_pg_force) else $error("pulse gen not forced");

   property p_lut_hold;
      s_settings_wr ##0 (n.sel != SEL_LOGIC) |=> $stable(s.lut);
   endproperty
   a_lut_hold: assert property (p_lut_hold) else $error("table changed");

   property p_xor_src;
      (counting && n.sel == SEL_LOGIC && n.lut == 4'h6) |=>
         s.cond.src == ($past(source_in) ^ $past(gate_in));
   endproperty
   a_xor_src: assert property (p_xor_src) else $error("derived source wrong");

   property p_bus_reset;
      (bus_reset && !n.bus_ignore) |=> (s.mode == MODE_NONE && !s.run && s.out_clear)
         ##1 !s.out_clear;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset missed");

   property p_len_hold;
      s_settings_wr ##0 !(bus_reset && !n.bus_ignore) |=> $stable(s.act_len);
   endproperty
   a_len_hold: assert property (p_len_hold) else $error("length applied early");

   property p_default;
      s_default_wr |=> s.sel == SEL_DIRECT && s.mode == MODE_NONE && !s.run &&
         s.pend_len == LEN_DEFAULT && s.bus_ignore == $past(s.bus_ignore);
   endproperty
   a_default: assert property (p_default) else $error("default incomplete");

   property p_freq;
      s.mode == MODE_PULSEGEN |-> s.freq_hz == FREQ_BASE_HZ + 15'(s.factor) * FREQ_STEP_HZ;
   endproperty
   a_freq: assert property (p_freq) else $error("frequency wrong");

   property p_len_ms;
      s.act_len == LEN_DEFAULT |-> s.len_ms == 10'h064;
   endproperty
   a_len_ms: assert property (p_len_ms) else $error("pulse length table wrong");
endmodule

/* hdl/counter_settings_pkg.sv */
// Constants, field layout and carrier types for the settings decoder
package counter_settings_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_WORD1  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_MODE   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

   localparam int CODE_MSB = 15;
   localparam int CODE_LSB = 10;
   localparam int SEL_MSB  = 9;
   localparam int SEL_LSB  = 8;
   localparam int LUT_MSB  = 7;
   localparam int LUT_LSB  = 4;
   localparam int BRST_BIT = 3;
   localparam int LEN_MSB  = 2;
   localparam int MODE_MSB = 2;
   localparam int FACT_MSB = 12;
   localparam int FACT_LSB = 8;
   localparam int ST_RUN   = 16;
   localparam int ST_ACT   = 12;

   localparam logic [5:0] CODE_SETTINGS = 6'h0c;
   localparam logic [5:0] CODE_DEFAULT  = 6'h0a;
   localparam logic [5:0] CODE_STOP     = 6'h08;
   localparam logic [5:0] CODE_START    = 6'h09;

   localparam logic [1:0] SEL_DIRECT   = 2'h0;
   localparam logic [1:0] SEL_BOUNCE   = 2'h1;
   localparam logic [1:0] SEL_PULSEGEN = 2'h2;
   localparam logic [1:0] SEL_LOGIC    = 2'h3;

   localparam logic [2:0] LEN_DEFAULT = 3'h2;
   localparam logic [9:0] PULSE_MS [0:7] = '{10'h00a, 10'h032, 10'h064, 10'h0c8,
                                             10'h12c, 10'h190, 10'h1f4, 10'h3e8};
   localparam logic [14:0] FREQ_BASE_HZ = 15'h03e8;
   localparam logic [14:0] FREQ_STEP_HZ = 15'h01f4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_NONE = 3'h0, MODE_FREQ = 3'h1, MODE_EVENT = 3'h2,
      MODE_TIME = 3'h3, MODE_PULSEGEN = 3'h4
   } mode_e;

   typedef enum logic [1:0] {WR_IDLE = 2'h0, WR_RESP = 2'h1} wr_e;

   typedef struct packed {
      logic src;
      logic gate;
      logic filt_100k;
      logic filt_bounce;
      logic pulsegen_setup;
      logic logic_active;
   } cond_out_s;
endpackage

/* tb/fieldbus_ctl.sv */
// Fieldbus controller model issuing register writes and reads
`timescale 1ns/1ps
module fieldbus_ctl
   import counter_settings_pkg::*;
(
   input  wire logic                                    aclk,
   output logic      [counter_settings_pkg::ADDR_W-1:0] awaddr,
   output logic                                         awvalid,
   input  wire logic                                    awready,
   output logic      [31:0]                             wdata,
   output logic      [3:0]                              wstrb,
   output logic                                         wvalid,
   input  wire logic                                    wready,
   input  wire logic                                    bvalid,
   output logic                                         bready,
   output logic      [counter_settings_pkg::ADDR_W-1:0] araddr,
   output logic                                         arvalid,
   input  wire logic                                    arready,
   input  wire logic                                    rvalid,
   output logic                                         rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // Address and data offered together, each dropped once taken
   task automatic write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic read(input logic [ADDR_W-1:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the settings decoder
`timescale 1ns/1ps
module tb;
   import counter_settings_pkg::*;
   logic                aclk = 1'b0;
   logic                aresetn = 1'b0;
   logic                bus_reset = 1'b0;
   logic                source_in = 1'b0;
   logic                gate_in = 1'b0;
   wire  [ADDR_W-1:0]   awaddr, araddr;
   wire                 awvalid, awready, wvalid, wready, bvalid, bready;
   wire                 arvalid, arready, rvalid, rready, count_run, out_clear;
   wire  [31:0]         wdata, rdata;
   wire  [3:0]          wstrb;
   wire  [1:0]          bresp, rresp;
   wire  cond_out_s     cond;
   wire  mode_e         mode;
   wire  [9:0]          pulse_len_ms;
   wire  [14:0]         pulse_freq_hz;
   int                  failures = 0;
   int                  compares = 0;
   int                  cycles = 0;
   logic [33:0]         exp_r [$];
   logic [1:0]          exp_b [$];
   logic [2:0]          pend = 3'h2;
   logic [2:0]          appl = 3'h2;
   logic [3:0]          tab = 4'h0;
   logic [1:0]          sel = 2'h0;
   logic                ign = 1'b0;
   logic                run = 1'b0;
   mode_e               md = MODE_NONE;
   logic [9:0]          ms [0:7] = '{10'h00a, 10'h032, 10'h064, 10'h0c8,
                                     10'h12c, 10'h190, 10'h1f4, 10'h3e8};

   always #2 aclk = ~aclk;
   counter_system_settings uut (.*);
   fieldbus_ctl ctl (.*);

   task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
      end
   endtask

   task automatic final_report;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Answers are matched in order against the oldest note
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
      if (rvalid && rready)
         check("read", {rresp, rdata}, exp_r.pop_front());
      if (bvalid && bready)
         check("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
   end

   function automatic logic [33:0] st();
      return {17'h0, run, 1'b0, appl, 2'h0, sel, tab, ign, pend};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      exp_b.push_back(r);
      ctl.write(a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      exp_r.push_back(e);
      ctl.read(a);
   endtask

   task automatic cmd(input logic [15:0] w);
      if (w[15:10] == CODE_SETTINGS) begin
         sel = (md == MODE_PULSEGEN) ? SEL_PULSEGEN : w[9:8];
         if (sel == SEL_LOGIC)
            tab = w[7:4];
         ign = w[3];
         pend = w[2:0];
      end else if (w[15:10] == CODE_DEFAULT) begin
         {pend, appl, sel, run} = {3'h2, 3'h2, 2'h0, 1'b0};
         md = MODE_NONE;
      end else if (w[15:10] == CODE_STOP) begin
         run = 1'b0;
      end else if (w[15:10] == CODE_START) begin
         run = (md == MODE_EVENT);
      end
      wr(ADDR_CMD, {16'h0, w}, RESP_OKAY);
   endtask

   task automatic setmode(input logic [2:0] m, input logic [4:0] f);
      md = (m inside {3'h1, 3'h2, 3'h3, 3'h4}) ? mode_e'(m) : MODE_NONE;
      run = m inside {3'h1, 3'h2, 3'h3};
      if (m == 3'h2)
         appl = pend;
      if (m == 3'h4)
         sel = SEL_PULSEGEN;
      wr(ADDR_MODE, {19'h0, f, 5'h0, m}, RESP_OKAY);
   endtask

   // Random source and gate, derived output checked two edges later
   task automatic cond_chk;
      logic [1:0] gs;
      logic       cnt;
      logic       lg;
      gs = 2'($urandom_range(3));
      // Logic and bounce only count in the measuring modes
      cnt = (md == MODE_FREQ) || (md == MODE_EVENT) || (md == MODE_TIME);
      lg = cnt && (sel == SEL_LOGIC);
      @(posedge aclk);
      gate_in <= gs[1];
      source_in <= gs[0];
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      check("src", cond.src, lg ? tab[gs] : gs[0]);
      check("gate", cond.gate, gs[1]);
      check("flags", {cond.filt_100k, cond.filt_bounce, cond.pulsegen_setup,
                      cond.logic_active},
            {sel == SEL_DIRECT, cnt && sel == SEL_BOUNCE, sel == SEL_PULSEGEN, lg});
   endtask

   initial begin
      int f;
      void'($urandom(76));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      check("len", pulse_len_ms, 10'h064);
      check("mode", mode, MODE_NONE);
      rd(ADDR_STATUS, st());
      cond_chk();
      setmode(3'h3, 5'h0);
      // Selection 01 suits mechanical contacts only
      for (int i = 0; i < 4; i++) begin
         cmd(16'(16'h30f0 | (i << 8)));
         cond_chk();
         rd(ADDR_STATUS, st());
      end
      setmode(3'h1, 5'h0);
      for (int t = 0; t < 16; t++) begin
         cmd(16'(16'h3300 | (t << 4) | t[2:0]));
         repeat (4) cond_chk();
      end
      cmd(16'h3d10);
      cmd(16'h3410);
      wr(ADDR_WORD1, 32'h0000_31f7, RESP_OKAY);
      rd(ADDR_STATUS, st());
      rd(ADDR_WORD1, {2'h0, 32'h0000_31f7});
      for (int l = 0; l < 8; l++) begin
         cmd(16'(16'h3100 | l));
         check("held", pulse_len_ms, ms[appl]);
         setmode(3'h2, 5'h0);
         check("applied", pulse_len_ms, ms[l]);
      end
      cmd(16'h3386);
      check("held", pulse_len_ms, ms[appl]);
      check("run", count_run, 1'b1);
      cond_chk();
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            cmd(16'h3388);
            setmode(3'h2, 5'h0);
         end
         @(posedge aclk);
         bus_reset <= 1'b1;
         @(posedge aclk);
         bus_reset <= 1'b0;
         @(negedge aclk);
         check("clr", out_clear, !ign);
         check("mode", mode, ign ? MODE_EVENT : MODE_NONE);
         check("run", count_run, ign);
         if (!ign) begin
            md = MODE_NONE;
            run = 1'b0;
         end
         @(negedge aclk);
         check("clr", out_clear, 1'b0);
         cond_chk();
      end
      cmd(16'h2000);
      check("stop", count_run, 1'b0);
      cmd(16'h2400);
      check("start", count_run, 1'b1);
      setmode(3'h6, 5'h0);
      check("mode", {mode, count_run}, {md, run});
      rd(ADDR_STATUS, st());
      f = $urandom_range(18);
      setmode(3'h4, f[4:0]);
      check("freq", pulse_freq_hz, 15'h3e8 + 15'(f) * 15'h1f4);
      check("mode", mode, MODE_PULSEGEN);
      cmd(16'h33f9);
      cond_chk();
      rd(ADDR_STATUS, st());
      cmd(16'h2800);
      check("len", pulse_len_ms, 10'h064);
      check("mode", {mode, count_run, pulse_freq_hz}, 34'h0);
      cond_chk();
      rd(ADDR_STATUS, st());
      // Unmapped place refused, status place not writable
      wr(8'h10, 32'h0000_3300, RESP_SLVERR);
      rd(8'h10, {RESP_SLVERR, 32'h0});
      wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
      rd(ADDR_CMD, {RESP_OKAY, 32'h0000_2800});
      rd(ADDR_STATUS, st());
      @(posedge aclk);
      final_report();
   end
endmodule
